// ==== logic/sequencer_pkg.sv ====
// Constants and types for the supply start-up and fault sequencer
package sequencer_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned UV_FILTER_US = 50;
  localparam int unsigned UV_FILTER_CYC = UV_FILTER_US * CLK_MHZ;
  localparam int unsigned LATCH_FILTER_US = 50;
  localparam int unsigned LATCH_FILTER_CYC = LATCH_FILTER_US * CLK_MHZ;
  localparam int unsigned OVERLOAD_MS = 118;
  localparam int unsigned OVERLOAD_CYC = OVERLOAD_MS * 1000 * CLK_MHZ;
  localparam int unsigned SOFTSTART_US = 4800;
  localparam int unsigned SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned LIMIT_W = 10;
  localparam logic [LIMIT_W-1:0] LIMIT_FULL = 10'h3FF;
  localparam logic [LIMIT_W-1:0] LIMIT_RESET = 10'h000;
  localparam logic [1:0] HICCUP_RESET = 2'h0;
  localparam logic [1:0] HICCUP_LAST = 2'h2;

  typedef struct packed {
    logic above_inhibit;
    logic above_turn_on;
    logic below_minimum;
    logic below_supply_undervoltage_lockout;
    logic below_hiccup;
    logic below_logic_reset;
  } supply_cmp_t;

  typedef struct packed {
    logic overload;
    logic thermal;
    logic ext_latch;
  } fault_in_t;

  typedef enum logic [4:0] {
    ST_PRECHARGE = 5'h01,
    ST_CHARGE = 5'h02,
    ST_RUN = 5'h04,
    ST_UV_WAIT = 5'h08,
    ST_HICCUP = 5'h10
  } seq_state_t;
endpackage

// ==== logic/supply_startup_fault_sequencer.sv ====
// Supply start-up, undervoltage and double-hiccup fault sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_startup_fault_sequencer
  import sequencer_pkg::*;
#(
  parameter int unsigned OVERLOAD_CYCLES = OVERLOAD_CYC,
  parameter int unsigned SOFTSTART_CYCLES = SOFTSTART_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic latch_variant_i,
  input wire supply_cmp_t supply_cmp_i,
  input wire fault_in_t fault_i,
  output logic startup_current_source_o,
  output logic small_precharge_source_o,
  output logic gate_drive_out_o,
  output logic self_supply_mode_o,
  output logic soft_start_trig_o,
  output logic [LIMIT_W-1:0] mod_limit_o,
  output logic latched_o
);
  supply_cmp_t cmp_meta_ff, cmp_ff;
  fault_in_t flt_meta_ff, flt_ff;
  seq_state_t state_ff, nxt_state;
  logic variant_taken_ff, latch_variant_ff;
  logic [CNT_W-1:0] uv_cnt_ff, lat_cnt_ff;
  logic [26:0] ovl_cnt_ff;
  logic [19:0] ss_cnt_ff;
  logic [1:0] pass_ff;
  logic ext_latch_ok_ff, overload_ok_ff, latched_ff, ss_run_ff;

  function automatic logic count_done(input logic [26:0] cnt, input int unsigned lim);
    count_done = (cnt >= 27'(lim - 1));
  endfunction

  // Two-stage synchronisers; first stage read only by the second
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_meta_ff <= '0;
      cmp_ff <= '0;
      flt_meta_ff <= '0;
      flt_ff <= '0;
    end else if (clk_en_i) begin
      cmp_meta_ff <= supply_cmp_i;
      cmp_ff <= cmp_meta_ff;
      flt_meta_ff <= fault_i;
      flt_ff <= flt_meta_ff;
    end
  end

  // Strap taken on first enabled edge after reset release
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      variant_taken_ff <= 1'b0;
      latch_variant_ff <= 1'b0;
    end else if (clk_en_i && !variant_taken_ff) begin
      variant_taken_ff <= 1'b1;
      latch_variant_ff <= latch_variant_i;
    end
  end

  wire logic uv_expired = count_done(27'(uv_cnt_ff), UV_FILTER_CYC);
  wire logic lat_expired = count_done(27'(lat_cnt_ff), LATCH_FILTER_CYC);
  wire logic ovl_expired = count_done(ovl_cnt_ff, OVERLOAD_CYCLES);
  wire logic ss_done = count_done(27'(ss_cnt_ff), SOFTSTART_CYCLES);

  // Filter counters
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_cnt_ff <= '0;
      ext_latch_ok_ff <= 1'b0;
      ovl_cnt_ff <= '0;
      overload_ok_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (!flt_ff.ext_latch) begin
        lat_cnt_ff <= '0;
      end else if (!lat_expired) begin
        lat_cnt_ff <= lat_cnt_ff + 1'b1;
      end
      ext_latch_ok_ff <= flt_ff.ext_latch && lat_expired;
      if (!flt_ff.overload || state_ff != ST_RUN) begin
        ovl_cnt_ff <= '0;
      end else if (!ovl_expired) begin
        ovl_cnt_ff <= ovl_cnt_ff + 1'b1;
      end
      overload_ok_ff <= flt_ff.overload && ovl_expired && state_ff == ST_RUN;
    end
  end

  wire logic uv_filtered = (state_ff == ST_UV_WAIT) && uv_expired;
  wire logic any_fault = flt_ff.thermal || ext_latch_ok_ff || overload_ok_ff;
  wire logic hiccup_entry = (state_ff == ST_RUN || state_ff == ST_UV_WAIT) && any_fault;
  wire logic set_latch = ext_latch_ok_ff || (overload_ok_ff && latch_variant_ff);
  wire logic fault_blocks = latched_ff || flt_ff.thermal || ext_latch_ok_ff;

  // Latched fault cleared only at the logic-reset level
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latched_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (set_latch) begin
        latched_ff <= 1'b1;
      end else if (cmp_ff.below_logic_reset) begin
        latched_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_PRECHARGE: begin
        if (cmp_ff.above_inhibit) begin
          nxt_state = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (cmp_ff.above_turn_on) begin
          nxt_state = fault_blocks ? ST_HICCUP : ST_RUN;
        end
      end
      ST_RUN: begin
        if (hiccup_entry) begin
          nxt_state = ST_HICCUP;
        end else if (cmp_ff.below_supply_undervoltage_lockout) begin
          nxt_state = ST_UV_WAIT;
        end
      end
      ST_UV_WAIT: begin
        // A fault during the dip must not slip back into run
        if (hiccup_entry) begin
          nxt_state = ST_HICCUP;
        end else if (!cmp_ff.below_supply_undervoltage_lockout) begin
          nxt_state = ST_RUN;
        end else if (uv_filtered) begin
          nxt_state = ST_HICCUP;
        end
      end
      ST_HICCUP: begin
        // Second turn-on with no fault ends the sequence
        if (cmp_ff.above_turn_on && pass_ff == HICCUP_LAST && !fault_blocks) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_PRECHARGE;
    endcase
    // Start-up states must be free to charge through the reset level
    if (cmp_ff.below_logic_reset && state_ff != ST_PRECHARGE && state_ff != ST_CHARGE) begin
      nxt_state = ST_PRECHARGE;
    end
  end

  // Pass counter: 0 discharge-1, 1 charge-1/discharge-2, 2 charge-2
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_PRECHARGE;
      pass_ff <= HICCUP_RESET;
      uv_cnt_ff <= '0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      uv_cnt_ff <= (state_ff == ST_UV_WAIT && !uv_expired) ? uv_cnt_ff + 1'b1 : '0;
      if (nxt_state == ST_HICCUP && state_ff != ST_HICCUP) begin
        pass_ff <= HICCUP_RESET;
      end else if (state_ff == ST_HICCUP) begin
        if (cmp_ff.below_hiccup && !startup_current_source_o) begin
          pass_ff <= (pass_ff == HICCUP_LAST) ? 2'h1 : pass_ff + 2'h1;
        end
      end
    end
  end

  // Source control; in hiccup, off until hiccup level, on until turn-on
  wire logic src_on_cond = cmp_ff.below_minimum && !cmp_ff.above_turn_on;
  wire logic src_off_cond = cmp_ff.above_turn_on;
  wire logic hic_charge = (state_ff == ST_HICCUP) && (pass_ff != HICCUP_RESET);
  logic nxt_src;
  always_comb begin
    nxt_src = startup_current_source_o;
    case (nxt_state)
      ST_PRECHARGE: nxt_src = 1'b0;
      ST_CHARGE: nxt_src = !src_off_cond;
      ST_HICCUP: begin
        if (src_off_cond) begin
          nxt_src = 1'b0;
        end else if (cmp_ff.below_hiccup || (hic_charge && startup_current_source_o)) begin
          nxt_src = 1'b1;
        end else begin
          nxt_src = 1'b0;
        end
      end
      default: begin
        if (src_off_cond) begin
          nxt_src = 1'b0;
        end else if (src_on_cond) begin
          nxt_src = 1'b1;
        end
      end
    endcase
  end

  wire logic ss_start = (nxt_state == ST_RUN) && (state_ff == ST_CHARGE || state_ff == ST_HICCUP);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      startup_current_source_o <= 1'b0;
      small_precharge_source_o <= 1'b0;
      gate_drive_out_o <= 1'b0;
      self_supply_mode_o <= 1'b0;
      soft_start_trig_o <= 1'b0;
      latched_o <= 1'b0;
    end else if (clk_en_i) begin
      startup_current_source_o <= nxt_src;
      small_precharge_source_o <= (nxt_state == ST_PRECHARGE);
      gate_drive_out_o <= (nxt_state == ST_RUN);
      self_supply_mode_o <= (nxt_state == ST_HICCUP);
      soft_start_trig_o <= ss_start;
      latched_o <= latched_ff;
    end
  end

  // Linear limit ramp; cycle count times full limit, widened to 40 bits
  wire logic [LIMIT_W-1:0] ramp_val = LIMIT_W'((40'(ss_cnt_ff) * 40'(LIMIT_FULL))
                                              / 40'(SOFTSTART_CYCLES));
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ss_cnt_ff <= '0;
      ss_run_ff <= 1'b0;
      mod_limit_o <= LIMIT_RESET;
    end else if (clk_en_i) begin
      if (ss_start) begin
        ss_cnt_ff <= '0;
        ss_run_ff <= 1'b1;
        mod_limit_o <= LIMIT_RESET;
      end else if (nxt_state != ST_RUN) begin
        ss_run_ff <= 1'b0;
        mod_limit_o <= LIMIT_RESET;
      end else if (ss_run_ff && !ss_done) begin
        ss_cnt_ff <= ss_cnt_ff + 1'b1;
        mod_limit_o <= ramp_val;
      end else begin
        mod_limit_o <= LIMIT_FULL;
      end
    end
  end

  property p_uv_drop;
    @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && state_ff == ST_RUN && cmp_ff.below_supply_undervoltage_lockout) |=> !gate_drive_out_o;
  endproperty
  a_uv_drop: assert property (p_uv_drop) else $error("drive not dropped on undervoltage");

  property p_src_off;
    @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && cmp_ff.above_turn_on) |=> !startup_current_source_o;
  endproperty
  a_src_off: assert property (p_src_off) else $error("source on above turn-on");

  property p_hiccup_no_drive;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_ff == ST_HICCUP) |-> !gate_drive_out_o && self_supply_mode_o;
  endproperty
  a_hiccup_no_drive: assert property (p_hiccup_no_drive) else $error("drive in hiccup");

  property p_latched_block;
    @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && latched_ff && !cmp_ff.below_logic_reset) |=> !gate_drive_out_o;
  endproperty
  a_latched_block: assert property (p_latched_block) else $error("drive while latched");

  property p_ss_trig;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(gate_drive_out_o) && $past(state_ff) != ST_UV_WAIT |-> soft_start_trig_o;
  endproperty
  a_ss_trig: assert property (p_ss_trig) else $error("no soft-start on turn-on");

  property p_precharge;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_ff == ST_PRECHARGE) |-> !startup_current_source_o;
  endproperty
  a_precharge: assert property (p_precharge) else $error("main source during precharge");

  property p_ext_latch;
    @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && ext_latch_ok_ff) |=> latched_ff;
  endproperty
  a_ext_latch: assert property (p_ext_latch) else $error("external latch not latched");

  property p_ovl_latch;
    @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && overload_ok_ff && latch_variant_ff) |=> latched_ff;
  endproperty
  a_ovl_latch: assert property (p_ovl_latch) else $error("overload not latched");

  property p_freeze;
    @(posedge ref_clk_i) disable iff (rst_i)
      !clk_en_i |=> $stable(gate_drive_out_o) && $stable(mod_limit_o)
        && $stable(startup_current_source_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while clock disabled");
endmodule // supply_startup_fault_sequencer
`default_nettype wire

// ==== tb/supply_model.sv ====
// Behavioural supply capacitor with its level comparators
`timescale 1ns/1ps
`default_nettype none
module supply_model
  import sequencer_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic startup_i,
  input wire logic precharge_i,
  input wire logic low_current_i,
  input wire logic hold_i,
  output wire supply_cmp_t supply_cmp_o
);
  int vcc_mv = 0;
  task automatic set_vcc(input int mv);
    vcc_mv = mv;
  endtask
  // Hold lets the bench park the supply at any level
  always @(posedge ref_clk_i) begin
    if (!hold_i) begin
      vcc_mv <= vcc_mv + (startup_i ? 10 : 0) + (precharge_i ? 1 : 0)
        - ((vcc_mv < 700) ? 0 : (low_current_i ? 2 : 4));
    end
  end
  assign supply_cmp_o = {vcc_mv > 670, vcc_mv >= 12700, vcc_mv <= 9900, vcc_mv < 9400,
    vcc_mv <= 5700, vcc_mv < 4000};
endmodule // supply_model
`default_nettype wire

// ==== tb/supply_startup_fault_sequencer_tb.sv ====
// Self-checking bench for the supply sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_startup_fault_sequencer_tb;
  import sequencer_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic variant = 1'b0;
  logic hold = 1'b0;
  logic clk_en = 1'b1;
  logic [LIMIT_W-1:0] lim_hold;
  fault_in_t fault = '0;
  supply_cmp_t cmp;
  logic src, pre, drv, lowi, trig, lat;
  logic [LIMIT_W-1:0] lim;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  wire logic [5:0] obs = {lat, trig, lowi, drv, pre, src};
  supply_startup_fault_sequencer #(.OVERLOAD_CYCLES(200), .SOFTSTART_CYCLES(100))
    supply_startup_fault_sequencer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
    .latch_variant_i(variant), .supply_cmp_i(cmp), .fault_i(fault),
    .startup_current_source_o(src), .small_precharge_source_o(pre), .gate_drive_out_o(drv),
    .self_supply_mode_o(lowi), .soft_start_trig_o(trig), .mod_limit_o(lim), .latched_o(lat));
  supply_model supply_model_i (.ref_clk_i(ref_clk_i), .startup_i(src), .precharge_i(pre),
    .low_current_i(lowi), .hold_i(hold), .supply_cmp_o(cmp));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling well above the longest expected run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic check_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_val(input string name, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wait_bit(input string name, input int idx, input logic lvl, input int max);
    int n;
    n = 0;
    while (obs[idx] !== lvl && n < max) begin
      @(negedge ref_clk_i);
      n++;
    end
    check_bit(name, lvl, obs[idx]);
  endtask
  task automatic do_reset(input logic v);
    rst_i = 1'b1;
    hold = 1'b0;
    fault = '0;
    variant = v;
    supply_model_i.set_vcc(0);
    idle(20);
    rst_i = 1'b0;
  endtask
  task automatic drive_stays_off(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge ref_clk_i);
      seen = seen | (drv !== 1'b0);
    end
    check_bit("drive seen while blocked", 1'b0, seen);
  endtask
  // Counts turn-on passes between hiccup entry and restart
  task automatic hiccup_restart();
    int falls, trigs, n;
    logic was;
    falls = 0;
    trigs = 0;
    n = 0;
    was = src;
    check_bit("drive in hiccup", 1'b0, drv);
    while (drv !== 1'b1 && n < 20000) begin
      @(negedge ref_clk_i);
      n++;
      if (was && !src && supply_model_i.vcc_mv >= 12700) falls++;
      if (!was && src) check_bit("source on at hiccup level", 1'b1, supply_model_i.vcc_mv <= 5710);
      if (trig === 1'b1) trigs++;
      was = src;
    end
    @(negedge ref_clk_i);
    if (trig === 1'b1) trigs++;
    check_val("turn-on passes", 10'h002, falls[9:0]);
    check_val("soft-start triggers", 10'h001, trigs[9:0]);
  endtask
  initial begin
    do_reset(1'b0);
    wait_bit("precharge source", 1, 1'b1, 5);
    check_bit("main source while grounded", 1'b0, src);
    wait_bit("main source above inhibit", 0, 1'b1, 900);
    wait_bit("drive at turn-on", 2, 1'b1, 2500);
    check_bit("source at turn-on", 1'b0, src);
    idle(50);
    check_bit("limit mid-ramp", 1'b1, lim > 0 && lim < LIMIT_FULL);
    // Disabled clock must hold the ramp where it stands
    lim_hold = lim;
    clk_en = 1'b0;
    idle(20);
    check_val("limit while frozen", lim_hold, lim);
    check_bit("drive while frozen", 1'b1, drv);
    clk_en = 1'b1;
    idle(60);
    check_val("limit after ramp", LIMIT_FULL, lim);
    wait_bit("source at minimum", 0, 1'b1, 1500);
    check_bit("supply at minimum", 1'b1, supply_model_i.vcc_mv <= 9900);
    hold = 1'b1;
    supply_model_i.set_vcc(9000);
    wait_bit("drive below lockout", 2, 1'b0, 4);
    idle(1000);
    supply_model_i.set_vcc(10000);
    wait_bit("drive after short dip", 2, 1'b1, 5);
    check_bit("hiccup after short dip", 1'b0, lowi);
    supply_model_i.set_vcc(9000);
    idle(4990);
    check_bit("hiccup inside filter", 1'b0, lowi);
    wait_bit("hiccup after filter", 3, 1'b1, 20);
    hold = 1'b0;
    hiccup_restart();
    fault.thermal = 1'b1;
    wait_bit("hiccup on thermal", 3, 1'b1, 10);
    fault.thermal = 1'b0;
    hiccup_restart();
    fault.ext_latch = 1'b1;
    idle(3000);
    fault.ext_latch = 1'b0;
    idle(10);
    check_bit("latch on short pulse", 1'b0, lat);
    fault.ext_latch = 1'b1;
    idle(4995);
    check_bit("latch inside filter", 1'b0, lat);
    wait_bit("latch after filter", 5, 1'b1, 20);
    fault.ext_latch = 1'b0;
    wait_bit("hiccup on latch", 3, 1'b1, 5);
    drive_stays_off(12000);
    check_bit("latch kept", 1'b1, lat);
    supply_model_i.set_vcc(3000);
    wait_bit("latch below logic reset", 5, 1'b0, 10);
    wait_bit("drive after power cycle", 2, 1'b1, 2500);
    fault.overload = 1'b1;
    idle(150);
    fault.overload = 1'b0;
    idle(10);
    fault.overload = 1'b1;
    idle(195);
    check_bit("hiccup before overload time", 1'b0, lowi);
    wait_bit("hiccup on overload", 3, 1'b1, 15);
    fault.overload = 1'b0;
    check_bit("latch in retry variant", 1'b0, lat);
    hiccup_restart();
    do_reset(1'b1);
    wait_bit("drive in latching variant", 2, 1'b1, 3500);
    fault.overload = 1'b1;
    wait_bit("latch on overload", 5, 1'b1, 220);
    fault.overload = 1'b0;
    drive_stays_off(10000);
    wrap_up();
  end
endmodule // supply_startup_fault_sequencer_tb
`default_nettype wire
